// ===== src/wtl_cfg.svh
// Offsets, field positions, stride and the reset word of the watchpoint trigger logic.
// Included by the memory and trigger modules; definitions only.
`ifndef WTL_CFG_SVH
`define WTL_CFG_SVH
`define WTL_OFF_CTRL 8'h00
`define WTL_OFF_STATUS 8'h04
`define WTL_OFF_IRQ_MASK 8'h08
`define WTL_OFF_BRK_EN 8'h0C
`define WTL_OFF_ARMED 8'h10
`define WTL_OFF_TRIG_CNT 8'h14
`define WTL_OFF_WP_BASE 8'h40
`define WTL_WP_STRIDE 8'h20
`define WTL_WP_CFG 8'h00
`define WTL_WP_VAL_A 8'h04
`define WTL_WP_CARE_A 8'h08
`define WTL_WP_VAL_B 8'h0C
`define WTL_WP_CARE_B 8'h10
`define WTL_CTRL_RUN_BIT 0
`define WTL_CTRL_STOP_BIT 1
`define WTL_WPCFG_ACT_BIT 0
`define WTL_WPCFG_TRANS_BIT 1
`define WTL_WPCFG_VALID_BIT 2
`define WTL_ST_TRIG_BIT 0
`define WTL_ST_RUN_BIT 1
`define WTL_RST_WORD 32'h0000_0000
`endif

// ===== src/wtl_pkg.sv
// Types shared by the watchpoint trigger logic files.
// Assumes a single sample clock domain.
package wtl_pkg;
   typedef enum logic [1:0] {
      WTL_IDLE = 2'b01,
      WTL_ARMED = 2'b10
   } wtl_state_t;
endpackage : wtl_pkg

// ===== src/wtl_cfg_mem.sv
// Small register-read memory holding per-watchpoint comparison words.
// Written from the bus side; read data comes out of a register.
`include "wtl_cfg.svh"
module wtl_cfg_mem #(
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk, // Sample clock
   input wire logic we, // Write strobe
   input wire logic [AW-1:0] waddr, // Write entry
   input wire logic [31:0] wdata, // Write word
   input wire logic [AW-1:0] raddr, // Read entry
   output logic [31:0] rdata // Registered read word
);
   logic [31:0] mem_reg [DEPTH];
   logic [31:0] rdata_reg;
   always_ff @(posedge clk) begin
      if (we) begin
         mem_reg[waddr] <= wdata;
      end
      rdata_reg <= mem_reg[raddr];
   end
   assign rdata = rdata_reg;
endmodule : wtl_cfg_mem

// ===== src/wtl_trigger.sv
// Watchpoint and breakpoint trigger logic with a classic Wishbone register slave.
// Assumes observed signals and breakpoint conditions are synchronous to clk.
// Contract
// - One comparison value selects value match; two select transition match. Here the transition bit of the watchpoint config word selects the form instead.
// - Value match triggers when the watched signal equals the value.
// - Transition match: first value one cycle, second value the next cycle.
// - Care masks let chosen bits be ignored during comparison.
// - A watchpoint without any configured value stays inactive.
// - Deactivated watchpoints keep their values but never arm or trigger.
// - Activations take hold in hardware only at the next run request.
// - Selected breakpoints become armed at the run request.
// - Trigger is formed from armed breakpoints and watchpoint matches.
// - Host runs, then waits for the trigger before collecting samples.
//
// Chosen here: the register offsets and the Wishbone register port.
`include "wtl_cfg.svh"
module wtl_trigger #(
   parameter int NWP = 4,
   parameter int WW = 32,
   parameter int NBP = 8
) (
   input wire logic clk, // Sample clock
   input wire logic srst, // Synchronous reset, active high
   input wire logic [NWP*WW-1:0] watch_sig, // Observed signals, one slice per watchpoint
   input wire logic [NBP-1:0] brk_hit, // Breakpoint conditions of the user design
   input wire logic [7:0] wb_adr_i, // Wishbone byte address
   input wire logic [31:0] wb_dat_i, // Wishbone write data
   output logic [31:0] wb_dat_o, // Wishbone read data
   input wire logic wb_we_i, // Wishbone write enable
   input wire logic [3:0] wb_sel_i, // Wishbone byte selects
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   output logic wb_ack_o, // Wishbone acknowledge
   output logic trigger, // One-cycle trigger to the sample buffer
   output logic running, // Armed and waiting for trigger
   output logic irq // Level interrupt
);
   localparam int AW = $clog2(NWP*4);

   wtl_pkg::wtl_state_t state_reg, state_next;
   logic [NWP-1:0] act_reg, act_next, trans_reg, trans_next, valid_reg, valid_next;
   logic [NWP-1:0] wp_arm_reg, wp_arm_next, trn_arm_reg, trn_arm_next;
   logic [NBP-1:0] brk_en_reg, brk_en_next, brk_arm_reg, brk_arm_next;
   logic [1:0] status_reg, status_next, mask_reg, mask_next;
   logic [15:0] trig_cnt_reg, trig_cnt_next;
   logic trig_reg, trig_next;
   logic ack_reg, ack_next;
   logic [31:0] dat_reg, dat_next;
   logic [NWP*WW-1:0] val_a_reg, care_a_reg, val_b_reg, care_b_reg, prev_reg;
   logic [NWP-1:0] hit_a, hit_b, wp_match;

   // Decode
   logic req, wr, rd;
   logic wp_space;
   logic [7:0] wp_rel;
   logic [$clog2(NWP)-1:0] wp_idx;
   logic [7:0] wp_field;
   logic run_cmd, stop_cmd;
   logic any_hit;
   logic [31:0] sel_mask;
   // Value and care words are mirrored into the small memory for readback
   logic wp_word;
   logic [2:0] wp_slot;
   logic [AW-1:0] mem_addr;
   logic mem_we;
   logic [31:0] mem_rdata;
   logic mem_rd_reg, mem_rd_next;

   assign req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wr = req && wb_we_i;
   assign rd = req && !wb_we_i;
   assign wp_space = wb_adr_i >= `WTL_OFF_WP_BASE && wb_adr_i < 8'(`WTL_OFF_WP_BASE + NWP * `WTL_WP_STRIDE);
   assign wp_rel = wb_adr_i - `WTL_OFF_WP_BASE;
   assign wp_idx = wp_rel[5 +: $clog2(NWP)];
   assign wp_field = {3'h0, wp_rel[4:0]};
   assign sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign run_cmd = wr && wb_adr_i == `WTL_OFF_CTRL && wb_sel_i[0] && wb_dat_i[`WTL_CTRL_RUN_BIT];
   assign stop_cmd = wr && wb_adr_i == `WTL_OFF_CTRL && wb_sel_i[0] && wb_dat_i[`WTL_CTRL_STOP_BIT];
   assign wp_word = wp_space && (wp_field == `WTL_WP_VAL_A || wp_field == `WTL_WP_CARE_A ||
      wp_field == `WTL_WP_VAL_B || wp_field == `WTL_WP_CARE_B);
   assign wp_slot = wp_field[4:2] - 3'h1;
   assign mem_addr = AW'({wp_idx, wp_slot[1:0]});
   assign mem_we = wr && wp_word;

   // Read word leaves a register in the ack cycle, so no extra wait state
   wtl_cfg_mem #(
      .DEPTH(NWP*4),
      .AW(AW)
   ) u_mem (
      .clk(clk),
      .we(mem_we),
      .waddr(mem_addr),
      .wdata(wb_dat_i & sel_mask),
      .raddr(mem_addr),
      .rdata(mem_rdata)
   );

   // Comparison words; registers rather than memory since every word is compared each cycle
   genvar g;
   generate
      for (g = 0; g < NWP; g++) begin : g_wp
         logic [WW-1:0] obs;
         logic wsel;
         assign obs = watch_sig[g*WW +: WW];
         assign wsel = wr && wp_space && wp_idx == g;
         always_ff @(posedge clk) begin
            if (srst) begin
               val_a_reg[g*WW +: WW] <= '0;
               care_a_reg[g*WW +: WW] <= '0;
               val_b_reg[g*WW +: WW] <= '0;
               care_b_reg[g*WW +: WW] <= '0;
               prev_reg[g*WW +: WW] <= '0;
            end else begin
               prev_reg[g*WW +: WW] <= obs;
               if (wsel && wp_field == `WTL_WP_VAL_A) begin
                  val_a_reg[g*WW +: WW] <= WW'(wb_dat_i & sel_mask);
               end
               if (wsel && wp_field == `WTL_WP_CARE_A) begin
                  care_a_reg[g*WW +: WW] <= WW'(wb_dat_i & sel_mask);
               end
               if (wsel && wp_field == `WTL_WP_VAL_B) begin
                  val_b_reg[g*WW +: WW] <= WW'(wb_dat_i & sel_mask);
               end
               if (wsel && wp_field == `WTL_WP_CARE_B) begin
                  care_b_reg[g*WW +: WW] <= WW'(wb_dat_i & sel_mask);
               end
            end
         end
         // Cleared care bits are don't-care
         assign hit_a[g] = ((obs ^ val_a_reg[g*WW +: WW]) & care_a_reg[g*WW +: WW]) == '0;
         assign hit_b[g] = ((obs ^ val_b_reg[g*WW +: WW]) & care_b_reg[g*WW +: WW]) == '0;
         // Value form vs transition form
         assign wp_match[g] = wp_arm_reg[g] && (trn_arm_reg[g]
            ? (((prev_reg[g*WW +: WW] ^ val_a_reg[g*WW +: WW]) & care_a_reg[g*WW +: WW]) == '0 && hit_b[g])
            : hit_a[g]);
      end
   endgenerate

   // Control, arming and trigger
   always_comb begin
      state_next = state_reg;
      act_next = act_reg;
      trans_next = trans_reg;
      valid_next = valid_reg;
      wp_arm_next = wp_arm_reg;
      trn_arm_next = trn_arm_reg;
      brk_en_next = brk_en_reg;
      brk_arm_next = brk_arm_reg;
      status_next = status_reg;
      mask_next = mask_reg;
      trig_cnt_next = trig_cnt_reg;
      trig_next = 1'b0;
      any_hit = (|wp_match) || (|(brk_arm_reg & brk_hit));
      if (wr && wp_space && wp_field == `WTL_WP_CFG && wb_sel_i[0]) begin
         act_next[wp_idx] = wb_dat_i[`WTL_WPCFG_ACT_BIT]; // Deactivation keeps values
         trans_next[wp_idx] = wb_dat_i[`WTL_WPCFG_TRANS_BIT];
         valid_next[wp_idx] = wb_dat_i[`WTL_WPCFG_VALID_BIT];
      end
      if (wr && wb_adr_i == `WTL_OFF_BRK_EN) begin
         brk_en_next = NBP'(wb_dat_i);
      end
      if (wr && wb_adr_i == `WTL_OFF_IRQ_MASK) begin
         mask_next = wb_dat_i[1:0];
      end
      if (wr && wb_adr_i == `WTL_OFF_STATUS) begin
         status_next = status_reg & ~wb_dat_i[1:0];
      end
      case (state_reg)
         wtl_pkg::WTL_IDLE: begin
            if (run_cmd) begin
               // Only valid, active watchpoints arm, and only here
               wp_arm_next = act_reg & valid_reg;
               trn_arm_next = trans_reg;
               brk_arm_next = brk_en_reg;
               state_next = wtl_pkg::WTL_ARMED;
            end
         end
         wtl_pkg::WTL_ARMED: begin
            if (stop_cmd || any_hit) begin
               trig_next = any_hit;
               wp_arm_next = '0;
               brk_arm_next = '0;
               state_next = wtl_pkg::WTL_IDLE;
            end
         end
         default: begin
            state_next = wtl_pkg::WTL_IDLE;
         end
      endcase
      // Set wins over a clear in the same cycle
      if (trig_next) begin
         status_next[`WTL_ST_TRIG_BIT] = 1'b1;
         trig_cnt_next = trig_cnt_reg + 16'h0001;
      end
      if (run_cmd && state_reg == wtl_pkg::WTL_IDLE) begin
         status_next[`WTL_ST_RUN_BIT] = 1'b1;
      end
   end

   // Bus answer: one wait-free ack, unmapped reads return zero
   always_comb begin
      ack_next = req;
      mem_rd_next = rd && wp_word;
      dat_next = 32'h0000_0000;
      if (rd) begin
         if (wb_adr_i == `WTL_OFF_CTRL) begin
            dat_next = {31'h0, state_reg == wtl_pkg::WTL_ARMED};
         end else if (wb_adr_i == `WTL_OFF_STATUS) begin
            dat_next = {30'h0, status_reg};
         end else if (wb_adr_i == `WTL_OFF_IRQ_MASK) begin
            dat_next = {30'h0, mask_reg};
         end else if (wb_adr_i == `WTL_OFF_BRK_EN) begin
            dat_next = 32'(brk_en_reg);
         end else if (wb_adr_i == `WTL_OFF_ARMED) begin
            dat_next = {16'(brk_arm_reg), 16'(wp_arm_reg)};
         end else if (wb_adr_i == `WTL_OFF_TRIG_CNT) begin
            dat_next = {16'h0, trig_cnt_reg};
         end else if (wp_space) begin
            case (wp_field)
               `WTL_WP_CFG: dat_next = {29'h0, valid_reg[wp_idx], trans_reg[wp_idx], act_reg[wp_idx]};
               `WTL_WP_VAL_A: dat_next = 32'(val_a_reg[wp_idx*WW +: WW]);
               `WTL_WP_CARE_A: dat_next = 32'(care_a_reg[wp_idx*WW +: WW]);
               `WTL_WP_VAL_B: dat_next = 32'(val_b_reg[wp_idx*WW +: WW]);
               `WTL_WP_CARE_B: dat_next = 32'(care_b_reg[wp_idx*WW +: WW]);
               default: dat_next = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= wtl_pkg::WTL_IDLE;
         act_reg <= '0;
         trans_reg <= '0;
         valid_reg <= '0;
         wp_arm_reg <= '0;
         trn_arm_reg <= '0;
         brk_en_reg <= '0;
         brk_arm_reg <= '0;
         status_reg <= '0;
         mask_reg <= '0;
         trig_cnt_reg <= '0;
         trig_reg <= 1'b0;
         ack_reg <= 1'b0;
         mem_rd_reg <= 1'b0;
         dat_reg <= `WTL_RST_WORD;
      end else begin
         state_reg <= state_next;
         act_reg <= act_next;
         trans_reg <= trans_next;
         valid_reg <= valid_next;
         wp_arm_reg <= wp_arm_next;
         trn_arm_reg <= trn_arm_next;
         brk_en_reg <= brk_en_next;
         brk_arm_reg <= brk_arm_next;
         status_reg <= status_next;
         mask_reg <= mask_next;
         trig_cnt_reg <= trig_cnt_next;
         trig_reg <= trig_next;
         ack_reg <= ack_next;
         mem_rd_reg <= mem_rd_next;
         dat_reg <= dat_next;
      end
   end

   assign trigger = trig_reg;
   assign running = state_reg == wtl_pkg::WTL_ARMED;
   assign irq = |(status_reg & mask_reg);
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = mem_rd_reg ? mem_rdata : dat_reg;
endmodule : wtl_trigger

// ===== sim/wtl_trigger_checker.sv
// Assertions on the ports of the watchpoint trigger block.
// Bound into wtl_trigger; one clock domain, sync reset.
module wtl_trigger_checker (
   input wire logic clk, // Sample clock
   input wire logic srst, // Sync reset
   input wire logic wb_cyc_i, // Cycle
   input wire logic wb_stb_i, // Strobe
   input wire logic wb_we_i, // Write enable
   input wire logic [7:0] wb_adr_i, // Address
   input wire logic [31:0] wb_dat_o, // Read data
   input wire logic wb_ack_o, // Acknowledge
   input wire logic trigger, // Trigger pulse
   input wire logic running // Armed level
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   AST_TRIG_PULSE: assert property (trigger |=> !trigger) else $error("trigger held too long");
   AST_TRIG_ARMED: assert property (trigger |-> $past(running)) else $error("trigger while idle");
   AST_TRIG_DISARM: assert property (trigger |-> !running) else $error("still armed after trigger");
   AST_RESET_CLEAR: assert property ($past(srst) |-> !running && !trigger) else $error("armed after reset");
   AST_RUN_CAUSE: assert property ($rose(running) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h00))
      else $error("armed without run write");
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data without ack");
endmodule : wtl_trigger_checker
bind wtl_trigger wtl_trigger_checker u_chk (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trigger(trigger),
   .running(running));

// ===== sim/wtl_user_model.sv
// Stand-in for the instrumented user design.
// Bench calls its tasks; values change just after a rising edge.
module wtl_user_model (
   input wire logic clk, // Sample clock
   output logic [127:0] watch_sig, // Watched words
   output logic [7:0] brk_hit // Breakpoint hits
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      watch_sig = 128'h0;
      brk_hit = 8'h00;
   end
   task automatic set_watch(input int g, input logic [31:0] v);
      @(posedge clk);
      watch_sig[g*32 +: 32] <= v;
   endtask : set_watch
   task automatic set_brk(input logic [7:0] v);
      @(posedge clk);
      brk_hit <= v;
   endtask : set_brk
endmodule : wtl_user_model

// ===== sim/test_wtl_trigger.sv
// Self-checking bench for the watchpoint trigger block.
// Classic Wishbone master tasks; a user model drives watched words.
module test_wtl_trigger;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, srst, cyc, stb, we, ack, trigger, running, irq;
   logic [7:0] adr;
   logic [31:0] wdat, rdat;
   logic [127:0] watch_sig;
   logic [7:0] brk_hit;
   int miscompares = 0;
   int check_count = 0;
   wtl_user_model usr (.clk(clk), .watch_sig(watch_sig), .brk_hit(brk_hit));
   wtl_trigger dut (.clk(clk), .srst(srst), .watch_sig(watch_sig), .brk_hit(brk_hit), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_ack_o(ack), .trigger(trigger), .running(running), .irq(irq));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   // Registered outputs are read at the edge, before that edge's updates land
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 64);
      q = rdat;
      check("ack", 32'h1, {31'h0, ack});
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(nm, e, q);
   endtask : rd
   task automatic run_chk;
      wr(8'h00, 32'h1);
      @(posedge clk);
      check("running", 32'h1, {31'h0, running});
   endtask : run_chk
   task automatic expect_trig(input logic e);
      logic seen;
      seen = 1'b0;
      repeat (8) begin
         @(posedge clk);
         if (trigger === 1'b1) seen = 1'b1;
      end
      check("trigger", {31'h0, e}, {31'h0, seen});
   endtask : expect_trig
   initial begin
      #40000;
      miscompares++;
      $display("watchdog expired");
      complete_run();
   end
   initial begin
      srst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h0;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rd("status", 8'h04, 32'h0);
      rd("armed", 8'h10, 32'h0);
      rd("unmapped", 8'h3C, 32'h0);
      $display("test reset done");
      wr(8'h40, 32'h5);
      wr(8'h44, 32'hA2);
      wr(8'h48, 32'hFFFF_FF0F);
      usr.set_watch(0, 32'hF2);
      expect_trig(1'b0);
      wr(8'h00, 32'h1);
      expect_trig(1'b1);
      rd("status", 8'h04, 32'h3);
      check("irq", 32'h0, {31'h0, irq});
      $display("test value match done");
      wr(8'h04, 32'h3);
      wr(8'h40, 32'h4);
      rd("val_a", 8'h44, 32'hA2);
      wr(8'h60, 32'h7);
      wr(8'h64, 32'h1);
      wr(8'h68, 32'hFFFF_FFFF);
      wr(8'h6C, 32'h2);
      wr(8'h70, 32'hFFFF_FFFF);
      wr(8'h80, 32'h1);
      run_chk();
      rd("armed", 8'h10, 32'h2);
      usr.set_watch(1, 32'h2);
      expect_trig(1'b0);
      usr.set_watch(1, 32'h1);
      expect_trig(1'b0);
      usr.set_watch(1, 32'h2);
      expect_trig(1'b1);
      $display("test transition done");
      wr(8'h04, 32'h3);
      wr(8'h60, 32'h6);
      wr(8'h08, 32'h1);
      wr(8'h0C, 32'h80);
      usr.set_brk(8'h01);
      run_chk();
      rd("armed", 8'h10, 32'h0080_0000);
      expect_trig(1'b0);
      usr.set_brk(8'h80);
      expect_trig(1'b1);
      check("irq", 32'h1, {31'h0, irq});
      rd("count", 8'h14, 32'h3);
      wr(8'h04, 32'h3);
      repeat (2) @(posedge clk);
      check("irq", 32'h0, {31'h0, irq});
      usr.set_brk(8'h00);
      run_chk();
      wr(8'h00, 32'h2);
      @(posedge clk);
      check("running", 32'h0, {31'h0, running});
      $display("test breakpoint done");
      complete_run();
   end
endmodule : test_wtl_trigger
